// ---- ser_model.sv ----
// serializer-side model reporting mode, input phy kind and lane count per link
`timescale 1ns/1ps
`default_nettype none
module ser_model (
  input  wire logic       clk,             // register clock
  input  wire logic [3:0] tun_req,         // links whose serializer tunnels
  input  wire logic [3:0] dphy_req,        // links whose serializer has d-phy inputs
  output logic      [3:0] ser_tunnel_seen, // tunnel mode reported
  output logic      [3:0] ser_dphy_seen,   // d-phy input reported
  output logic      [7:0] ser_lane_count   // lane count, 2 bits per link
);
  // status levels move only on the clock, like a link status
  always_ff @(posedge clk)
  begin
    ser_tunnel_seen <= tun_req;
    ser_dphy_seen   <= dphy_req;
    ser_lane_count  <= 8'he4;
  end
endmodule
`default_nettype wire

// ---- stream_fifo.sv ----
// first-word-fall-through fifo with registered outputs for the tagged video stream
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,       // register clock
  input  wire logic             rst_n,     // synchronised reset, active low
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_word,   // word in
  output logic                  out_valid, // word held at output
  input  wire logic             out_ready, // sink takes the word
  output logic      [WIDTH-1:0] out_word   // word out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             load;

  // handshakes on both sides
  assign push       = in_valid && in_ready;
  assign load       = (count != '0) && (!out_valid || out_ready);
  assign next_count = count + CW'(push) - CW'(load);

  // storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_word;
    end
  end

  // pointers, occupancy and registered ready
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (load)
      begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count    <= next_count;
      in_ready <= (next_count != FULL_COUNT);
    end
  end

  // output register, stalls while the sink holds off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_word  <= '0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_word  <= mem[rd_ptr];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the tunnel/pixel mode configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, reg_rvalid;
  logic        quad_height_aggregation = 1'b0, in_valid = 1'b0, in_ready, out_valid, out_ready = 1'b0, out_tunnel;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, ser_lane_count, link_lane_count, link_out_phy, pixel_out_phy = 8'he4;
  logic [3:0]  tun_req = 4'h0, dphy_req = 4'h0, ser_tunnel_seen, ser_dphy_seen, pixel_remap_enable = 4'h2;
  logic [3:0]  link_tunnel_mode, link_conversion, pipe_lane_kind, link_reset;
  logic [1:0]  in_link = 2'h0, in_vc = 2'h1, out_phy, out_link, out_vc;
  logic [5:0]  in_dt = 6'h2b, out_dt;
  logic [4:0]  in_bpp = 5'h08, out_bpp;
  logic [31:0] in_data = 32'h0, out_data;
  int          failures = 0, total_checks = 0, i;
  always #25 clk = ~clk;
  ser_model partner (.clk, .tun_req, .dphy_req, .ser_tunnel_seen, .ser_dphy_seen, .ser_lane_count);
  tunnel_mode_link_config uut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .reg_rvalid, .ser_tunnel_seen, .ser_dphy_seen, .ser_lane_count, .pipe_lane_kind_detected(4'h3),
    .pipe_lane_kind_override(4'hc), .quad_height_aggregation, .pixel_remap_enable, .pixel_dt_map({4{6'h12}}),
    .pixel_vc_map(8'hff), .pixel_bpp_map({4{5'h0c}}), .pixel_out_phy, .in_valid, .in_ready, .in_link, .in_dt,
    .in_vc, .in_bpp, .in_data, .out_valid, .out_ready, .out_tunnel, .out_phy, .out_link, .out_dt, .out_vc,
    .out_bpp, .out_data, .link_tunnel_mode, .link_conversion, .link_lane_count, .link_out_phy,
    .pipe_lane_kind, .link_reset);
  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic conclude;
  begin
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk({reg_rvalid, reg_rdata}, {1'b1, e});
  end
  endtask
  // one word in, wait for it at the output, compare tag, routing and fields
  task automatic pass(input logic [1:0] l, input logic [31:0] d, input logic [17:0] e);
    int n;
  begin
    @(posedge clk);
    in_valid <= 1'b1;
    in_link <= l;
    in_data <= d;
    @(posedge clk);
    in_valid <= 1'b0;
    for (n = 0; n < 20 && out_valid !== 1'b1; n++)
      @(posedge clk) #1;
    if (n == 20)
    begin
      failures++;
      conclude();
    end
    chk({out_link, out_tunnel, out_phy, out_dt, out_vc, out_bpp}, e);
    chk(out_data, d);
    @(posedge clk);
    out_ready <= 1'b1;
    @(posedge clk);
    out_ready <= 1'b0;
    #1 chk({in_ready, out_valid}, 2'b10);
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 4; i++)
    begin
      rd(tunnel_cfg_pkg::ENABLE_ADDR[i], 8'h08);
      rd(tunnel_cfg_pkg::DETECT_ADDR[i], 8'h10);
    end
    rd(tunnel_cfg_pkg::STATUS_ADDR, 8'h00);
    rd(16'h0000, 8'h00);
    tun_req <= 4'b0101;
    dphy_req <= 4'b0001;
    repeat (6) @(posedge clk);
    rd(tunnel_cfg_pkg::STATUS_ADDR, 8'h05);
    chk(link_tunnel_mode, 4'b0101);
    chk(link_conversion, 4'b0001);
    chk(link_lane_count, 8'he4);
    wr(tunnel_cfg_pkg::DETECT_ADDR[2], 8'h70);
    wr(tunnel_cfg_pkg::DETECT_ADDR[3], 8'hff);
    wr(tunnel_cfg_pkg::ENABLE_ADDR[3], 8'hef);
    rd(tunnel_cfg_pkg::DETECT_ADDR[3], 8'hf6);
    rd(tunnel_cfg_pkg::ENABLE_ADDR[3], 8'h09);
    chk(link_tunnel_mode, 4'b1001);
    chk(link_conversion, 4'b1001);
    chk(link_out_phy, 8'hf5);
    chk(link_lane_count, 8'h64);
    @(posedge clk) quad_height_aggregation <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(pipe_lane_kind, 4'h3);
    wr(tunnel_cfg_pkg::STATUS_ADDR, 8'h80);
    rd(tunnel_cfg_pkg::STATUS_ADDR, 8'h85);
    chk(pipe_lane_kind, 4'hc);
    pass(2'd0, 32'hdeadbeef, {2'd0, 1'b1, 2'b01, 6'h2b, 2'h1, 5'h08});
    pass(2'd1, 32'h01234567, {2'd1, 1'b0, 2'b01, 6'h12, 2'h3, 5'h0c});
    wr(16'h0018, 8'h21);
    #1 chk(link_reset, 4'b0011);
    rd(16'h0018, 8'h20);
    chk(link_reset, 4'b0010);
    conclude();
  end
endmodule
`default_nettype wire

// ---- tunnel_cfg_pkg.sv ----
// constants shared by the tunnel/pixel mode configuration block and its stream fifo
package tunnel_cfg_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int LINKS      = 4;
  localparam int ADDR_W     = 16;
  localparam int REG_W      = 8;
  localparam int FIFO_DEPTH = 32;

  // ****************************************
  // register offsets (byte addresses on the register port)
  // ****************************************
  localparam logic [LINKS-1:0][ADDR_W-1:0] ENABLE_ADDR = {16'h09f6, 16'h09b6, 16'h0976, 16'h0936};
  localparam logic [LINKS-1:0][ADDR_W-1:0] DETECT_ADDR = {16'h09f9, 16'h09b9, 16'h0979, 16'h0939};
  localparam logic [ADDR_W-1:0]            STATUS_ADDR     = 16'h1260;
  localparam logic [ADDR_W-1:0]            LINK_RESET_ADDR = 16'h0018;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [REG_W-1:0] ENABLE_RESET     = 8'h08;
  localparam logic [REG_W-1:0] DETECT_RESET     = 8'h10;
  localparam logic [REG_W-1:0] STATUS_RESET     = 8'h00;
  localparam logic [REG_W-1:0] LINK_RESET_RESET = 8'h00;
  localparam logic [REG_W-1:0] ENABLE_WMASK     = 8'h19;
  localparam logic [REG_W-1:0] DETECT_WMASK     = 8'hf6;
  localparam logic [REG_W-1:0] STATUS_WMASK     = 8'h80;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TUNNEL_ENABLE_BIT  = 0;  // tunnel_enable_bit
  localparam int LANES_LO           = 3;  // manual c-phy lane count, 2 bits
  localparam int LANE_DETECT_DIS    = 7;  // serializer lane-count detect disable
  localparam int TUNNEL_DETECT_DIS  = 6;  // auto_tunnel_detect_disable
  localparam int OUT_PHY_LO         = 4;  // tunnel_output_phy_select, 2 bits
  localparam int CONV_MANUAL_BIT    = 2;  // conversion_manual_value
  localparam int CONV_OVERRIDE_BIT  = 1;  // conversion_override_enable
  localparam int KIND_OVERRIDE_BIT  = 7;  // lane_kind_override_enable
  localparam int HOLD_LO            = 4;  // held link resets, 4 bits
  localparam int PULSE_LO           = 0;  // link_pulse_reset, 4 bits
  localparam int FLAGS_LO           = 0;  // tunnel-detected flags, 4 bits

  // ****************************************
  // stream word layout
  // ****************************************
  localparam int DATA_W  = 32;
  localparam int BPP_W   = 5;
  localparam int DT_W    = 6;
  localparam int VC_W    = 2;
  localparam int LINK_W  = 2;
  localparam int PHY_W   = 2;
  localparam int LANE_W  = 2;
  localparam int DATA_LO = 0;
  localparam int BPP_LO  = DATA_LO + DATA_W;
  localparam int DT_LO   = BPP_LO + BPP_W;
  localparam int VC_LO   = DT_LO + DT_W;
  localparam int LINK_LO = VC_LO + VC_W;
  localparam int PHY_LO  = LINK_LO + LINK_W;
  localparam int TUN_BIT = PHY_LO + PHY_W;
  localparam int WORD_W  = TUN_BIT + 1;

endpackage

// ---- tunnel_mode_link_config.sv ----
// per-link pixel/tunnel mode configuration, detection and tagged stream path
`timescale 1ns/1ps
`default_nettype none
module tunnel_mode_link_config (
  input  wire logic        clk,                      // register clock, 20 MHz
  input  wire logic        resetn,                   // async reset, active low
  input  wire logic [15:0] reg_addr,                 // register address
  input  wire logic [7:0]  reg_wdata,                // write data
  input  wire logic        reg_write,                // write strobe
  input  wire logic        reg_read,                 // read strobe
  output logic      [7:0]  reg_rdata,                // read data
  output logic             reg_rvalid,               // read data valid pulse
  input  wire logic [3:0]  ser_tunnel_seen,          // link reports tunnel serializer
  input  wire logic [3:0]  ser_dphy_seen,            // link reports d-phy serializer
  input  wire logic [7:0]  ser_lane_count,           // detected lane count per link
  input  wire logic [3:0]  pipe_lane_kind_detected,  // detected c-phy mode per pipe
  input  wire logic [3:0]  pipe_lane_kind_override,  // programmed c-phy mode per pipe
  input  wire logic        quad_height_aggregation,  // quad-height aggregation active
  input  wire logic [3:0]  pixel_remap_enable,       // per-link pixel rewrite enable
  input  wire logic [23:0] pixel_dt_map,             // new data type per link
  input  wire logic [7:0]  pixel_vc_map,             // new virtual channel per link
  input  wire logic [19:0] pixel_bpp_map,            // new bpp per link
  input  wire logic [7:0]  pixel_out_phy,            // output phy per pixel link
  input  wire logic        in_valid,                 // stream word offered
  output logic             in_ready,                 // stream word accepted
  input  wire logic [1:0]  in_link,                  // source link of word
  input  wire logic [5:0]  in_dt,                    // data type
  input  wire logic [1:0]  in_vc,                    // virtual channel
  input  wire logic [4:0]  in_bpp,                   // bits per pixel
  input  wire logic [31:0] in_data,                  // payload
  output logic             out_valid,                // output word valid
  input  wire logic        out_ready,                // output sink ready
  output logic             out_tunnel,               // word belongs to tunnel class
  output logic      [1:0]  out_phy,                  // destination phy
  output logic      [1:0]  out_link,                 // source link
  output logic      [5:0]  out_dt,                   // data type
  output logic      [1:0]  out_vc,                   // virtual channel
  output logic      [4:0]  out_bpp,                  // bits per pixel
  output logic      [31:0] out_data,                 // payload
  output logic      [3:0]  link_tunnel_mode,         // link runs in tunnel mode
  output logic      [3:0]  link_conversion,          // d-phy to c-phy conversion on
  output logic      [7:0]  link_lane_count,          // c-phy lane count per link
  output logic      [7:0]  link_out_phy,             // tunnel output phy per link
  output logic      [3:0]  pipe_lane_kind,           // c-phy mode used per pipe
  output logic      [3:0]  link_reset                // link data path reset
);

  // ****************************************
  // reset and input synchronisers
  // ****************************************
  logic        rst_meta;
  logic        rst_n;
  logic [15:0] det_meta;
  logic [15:0] det_sync;
  logic [3:0]  det_tunnel;
  logic [3:0]  det_dphy;
  logic [7:0]  det_lanes;

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // detection levels come from the link clock domain; quasi-static
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      det_meta <= '0;
      det_sync <= '0;
    end
    else
    begin
      det_meta <= {ser_lane_count, ser_dphy_seen, ser_tunnel_seen};
      det_sync <= det_meta;
    end
  end

  assign det_tunnel = det_sync[3:0];
  assign det_dphy   = det_sync[7:4];
  assign det_lanes  = det_sync[15:8];

  // ****************************************
  // register file
  // ****************************************
  logic [3:0][7:0] enable_reg;
  logic [3:0][7:0] detect_reg;
  logic [7:0]      status_reg;
  logic [3:0]      hold_reset;
  logic [3:0]      next_tunnel;
  logic [3:0]      next_conv;
  logic [7:0]      next_lanes;
  logic [7:0]      next_rdata;

  genvar gi;
  generate
    for (gi = 0; gi < tunnel_cfg_pkg::LINKS; gi++)
    begin : g_link
      // tunnel control register, unused bits read zero
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          enable_reg[gi] <= tunnel_cfg_pkg::ENABLE_RESET;
        end
        else if (reg_write && reg_addr == tunnel_cfg_pkg::ENABLE_ADDR[gi])
        begin
          enable_reg[gi] <= reg_wdata & tunnel_cfg_pkg::ENABLE_WMASK;
        end
      end

      // detection control register
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          detect_reg[gi] <= tunnel_cfg_pkg::DETECT_RESET;
        end
        else if (reg_write && reg_addr == tunnel_cfg_pkg::DETECT_ADDR[gi])
        begin
          detect_reg[gi] <= reg_wdata & tunnel_cfg_pkg::DETECT_WMASK;
        end
      end

      // mode selection per link, independent of the others
      always_comb
      begin
        next_tunnel[gi] = detect_reg[gi][tunnel_cfg_pkg::TUNNEL_DETECT_DIS]
                        ? enable_reg[gi][tunnel_cfg_pkg::TUNNEL_ENABLE_BIT]
                        : det_tunnel[gi];
        next_conv[gi]   = detect_reg[gi][tunnel_cfg_pkg::CONV_OVERRIDE_BIT]
                        ? detect_reg[gi][tunnel_cfg_pkg::CONV_MANUAL_BIT]
                        : next_tunnel[gi] & det_dphy[gi];
        next_lanes[gi*2 +: 2] = detect_reg[gi][tunnel_cfg_pkg::LANE_DETECT_DIS]
                              ? enable_reg[gi][tunnel_cfg_pkg::LANES_LO +: tunnel_cfg_pkg::LANE_W]
                              : det_lanes[gi*2 +: 2];
      end

      // registered mode outputs
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          link_tunnel_mode[gi]    <= 1'b0;
          link_conversion[gi]     <= 1'b0;
          link_lane_count[gi*2 +: 2] <= 2'h0;
          link_out_phy[gi*2 +: 2]    <= 2'h0;
          pipe_lane_kind[gi]      <= 1'b0;
        end
        else
        begin
          link_tunnel_mode[gi]    <= next_tunnel[gi];
          link_conversion[gi]     <= next_conv[gi];
          link_lane_count[gi*2 +: 2] <= next_lanes[gi*2 +: 2];
          link_out_phy[gi*2 +: 2]    <= detect_reg[gi][tunnel_cfg_pkg::OUT_PHY_LO +: tunnel_cfg_pkg::PHY_W];
          pipe_lane_kind[gi] <= (status_reg[tunnel_cfg_pkg::KIND_OVERRIDE_BIT] && quad_height_aggregation)
                                ? pipe_lane_kind_override[gi]
                                : pipe_lane_kind_detected[gi];
        end
      end
    end
  endgenerate

  // status register: only the override enable is stored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_reg <= tunnel_cfg_pkg::STATUS_RESET;
    end
    else if (reg_write && reg_addr == tunnel_cfg_pkg::STATUS_ADDR)
    begin
      status_reg <= reg_wdata & tunnel_cfg_pkg::STATUS_WMASK;
    end
  end

  // link reset: held bits stay, one-shot bits last one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_reset <= tunnel_cfg_pkg::LINK_RESET_RESET[tunnel_cfg_pkg::HOLD_LO +: 4];
      link_reset <= 4'h0;
    end
    else if (reg_write && reg_addr == tunnel_cfg_pkg::LINK_RESET_ADDR)
    begin
      hold_reset <= reg_wdata[tunnel_cfg_pkg::HOLD_LO +: 4];
      link_reset <= reg_wdata[tunnel_cfg_pkg::HOLD_LO +: 4] | reg_wdata[tunnel_cfg_pkg::PULSE_LO +: 4];
    end
    else
    begin
      link_reset <= hold_reset;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 8'h00;
    for (int k = 0; k < tunnel_cfg_pkg::LINKS; k++)
    begin
      if (reg_addr == tunnel_cfg_pkg::ENABLE_ADDR[k])
      begin
        next_rdata = enable_reg[k];
      end
      if (reg_addr == tunnel_cfg_pkg::DETECT_ADDR[k])
      begin
        next_rdata = detect_reg[k];
      end
    end
    if (reg_addr == tunnel_cfg_pkg::STATUS_ADDR)
    begin
      next_rdata = status_reg | {4'h0, det_tunnel};
    end
    if (reg_addr == tunnel_cfg_pkg::LINK_RESET_ADDR)
    begin
      next_rdata = {hold_reset, 4'h0};  // one-shot bits read zero
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_read;
      reg_rdata  <= reg_read ? next_rdata : 8'h00;
    end
  end

  // ****************************************
  // stream path
  // ****************************************
  logic                               in_tunnel;
  logic [tunnel_cfg_pkg::DT_W-1:0]    word_dt;
  logic [tunnel_cfg_pkg::VC_W-1:0]    word_vc;
  logic [tunnel_cfg_pkg::BPP_W-1:0]   word_bpp;
  logic [tunnel_cfg_pkg::PHY_W-1:0]   word_phy;
  logic                               fifo_in_valid;
  logic [tunnel_cfg_pkg::WORD_W-1:0]  fifo_in_word;
  logic [tunnel_cfg_pkg::WORD_W-1:0]  fifo_out_word;

  // tag, route and optionally rewrite each word
  always_comb
  begin
    in_tunnel = link_tunnel_mode[in_link];
    word_dt   = in_dt;
    word_vc   = in_vc;
    word_bpp  = in_bpp;
    word_phy  = in_tunnel ? link_out_phy[in_link*2 +: 2] : pixel_out_phy[in_link*2 +: 2];
    if (!in_tunnel && pixel_remap_enable[in_link])
    begin
      word_dt  = pixel_dt_map[in_link*6 +: 6];
      word_vc  = pixel_vc_map[in_link*2 +: 2];
      word_bpp = pixel_bpp_map[in_link*5 +: 5];
    end
  end

  // words of a link held in reset are taken and dropped
  assign fifo_in_valid = in_valid && !link_reset[in_link];
  assign fifo_in_word  = {in_tunnel, word_phy, in_link, word_vc, word_dt, word_bpp, in_data};

  stream_fifo #(
    .WIDTH (tunnel_cfg_pkg::WORD_W),
    .DEPTH (tunnel_cfg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (in_ready),
    .in_word   (fifo_in_word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_word  (fifo_out_word)
  );

  // split the registered fifo word onto the output ports
  assign out_tunnel = fifo_out_word[tunnel_cfg_pkg::TUN_BIT];
  assign out_phy    = fifo_out_word[tunnel_cfg_pkg::PHY_LO +: tunnel_cfg_pkg::PHY_W];
  assign out_link   = fifo_out_word[tunnel_cfg_pkg::LINK_LO +: tunnel_cfg_pkg::LINK_W];
  assign out_vc     = fifo_out_word[tunnel_cfg_pkg::VC_LO +: tunnel_cfg_pkg::VC_W];
  assign out_dt     = fifo_out_word[tunnel_cfg_pkg::DT_LO +: tunnel_cfg_pkg::DT_W];
  assign out_bpp    = fifo_out_word[tunnel_cfg_pkg::BPP_LO +: tunnel_cfg_pkg::BPP_W];
  assign out_data   = fifo_out_word[tunnel_cfg_pkg::DATA_LO +: tunnel_cfg_pkg::DATA_W];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_pulse_write;
    reg_write && reg_addr == tunnel_cfg_pkg::LINK_RESET_ADDR && reg_wdata[0] && !reg_wdata[4];
  endsequence
  sequence seq_pulse_seen;
    link_reset[0] ##1 (!link_reset[0] || reg_write);
  endsequence
  AST_PULSE_SELF_CLEAR: assert property (seq_pulse_write |=> seq_pulse_seen)
    else $error("one-shot link reset did not last exactly one cycle");
  AST_TUNNEL_AUTO: assert property (!detect_reg[0][tunnel_cfg_pkg::TUNNEL_DETECT_DIS]
    |=> link_tunnel_mode[0] == $past(det_tunnel[0]))
    else $error("link a did not follow detected tunnel mode");
  AST_TUNNEL_MANUAL: assert property (detect_reg[1][tunnel_cfg_pkg::TUNNEL_DETECT_DIS]
    |=> link_tunnel_mode[1] == $past(enable_reg[1][tunnel_cfg_pkg::TUNNEL_ENABLE_BIT]))
    else $error("link b ignored manual tunnel enable");
  AST_CONV_OVERRIDE: assert property (detect_reg[2][tunnel_cfg_pkg::CONV_OVERRIDE_BIT]
    |=> link_conversion[2] == $past(detect_reg[2][tunnel_cfg_pkg::CONV_MANUAL_BIT]))
    else $error("link c conversion override not applied");
  AST_CONV_AUTO: assert property (!detect_reg[0][tunnel_cfg_pkg::CONV_OVERRIDE_BIT]
    |=> link_conversion[0] == ($past(next_tunnel[0]) && $past(det_dphy[0])))
    else $error("link a automatic conversion wrong");
  AST_LANE_MANUAL: assert property (detect_reg[3][tunnel_cfg_pkg::LANE_DETECT_DIS]
    |=> link_lane_count[7:6] == $past(enable_reg[3][tunnel_cfg_pkg::LANES_LO +: tunnel_cfg_pkg::LANE_W]))
    else $error("link d manual lane count not used");
  AST_PHY_MAP: assert property (reg_write && reg_addr == tunnel_cfg_pkg::DETECT_ADDR[0]
    ##1 !(reg_write && reg_addr == tunnel_cfg_pkg::DETECT_ADDR[0])
    |=> link_out_phy[1:0] == $past(reg_wdata[5:4], 2))
    else $error("link a output phy does not match written value");
  AST_STATUS_READ: assert property (reg_read && reg_addr == tunnel_cfg_pkg::STATUS_ADDR
    |=> reg_rvalid && reg_rdata[3:0] == $past(det_tunnel))
    else $error("status read did not return tunnel flags");
  AST_PIPE_KIND: assert property (status_reg[tunnel_cfg_pkg::KIND_OVERRIDE_BIT] && quad_height_aggregation
    |=> pipe_lane_kind == $past(pipe_lane_kind_override))
    else $error("pipe lane kind override ignored");
  AST_TUNNEL_PASS: assert property (fifo_in_valid && in_tunnel
    |-> fifo_in_word[tunnel_cfg_pkg::DT_LO +: tunnel_cfg_pkg::DT_W] == in_dt
        && fifo_in_word[tunnel_cfg_pkg::BPP_LO +: tunnel_cfg_pkg::BPP_W] == in_bpp
        && fifo_in_word[tunnel_cfg_pkg::VC_LO +: tunnel_cfg_pkg::VC_W] == in_vc)
    else $error("tunnel word was altered");

endmodule
`default_nettype wire
